// File: inc/esp_map.svh
// Bit positions, counts and the settle wait for the serial program port
`ifndef ESP_MAP_SVH
`define ESP_MAP_SVH

// Frame layout, bit 0 is the first bit shifted in
`define ESP_FRAME_BITS 16
`define ESP_ADDR_LO 0
`define ESP_ADDR_HI 1
`define ESP_RW_BIT 2
`define ESP_DATA_LO 8
`define ESP_DATA_HI 15

// Direction bit value that requests a read
`define ESP_RW_READ 1'b1

// Shift clock counts within a frame
`define ESP_CNT_W 5
`define ESP_CNT_RW 5'h02
`define ESP_CNT_SO_FIRST 5'h07
`define ESP_CNT_SO_LAST 5'h0e
`define ESP_CNT_LAST 5'h0f
`define ESP_CNT_MAX 5'h1f

// System clock cycles to wait after the strobe falls
`define ESP_SETTLE 2'h3

// Number of stored configuration registers
`define ESP_NV_COUNT 2

`endif

// File: inc/esp_pkg.sv
// Types shared by the serial program port
package esp_pkg;
    // Frame tracking state in the system domain
    typedef enum logic [1:0] {
        ESP_IDLE = 2'b00,
        ESP_OPEN = 2'b01,
        ESP_SETTLE = 2'b10
    } esp_state_t;

    // One stored configuration byte
    typedef logic [7:0] esp_byte_t;

    // Register address carried in the frame
    typedef logic [1:0] esp_addr_t;
endpackage

// File: logic/esp_sync.sv
// Two flip-flop synchroniser for a group of quasi-static levels
`timescale 1ns/1ps
module esp_sync #(
    parameter int WIDTH = 1
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic en_in,
    // Levels from another domain
    input wire logic [WIDTH-1:0] d_in,
    // Synchronised levels
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r; // First stage, read only by second stage
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r; // Second stage
    logic [WIDTH-1:0] sync_nxt;

    // Next values, hold while disabled
    always_comb begin
        meta_nxt = meta_r;
        sync_nxt = sync_r;
        if (!rst_b_in) begin
            meta_nxt = '0;
            sync_nxt = '0;
        end else if (en_in) begin
            meta_nxt = d_in;
            sync_nxt = meta_r;
        end
    end

    // Register stages
    always_ff @(posedge clk_in) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign q_out = sync_r;
endmodule

// File: logic/esp_top.sv
// Serial program and read-back port for two stored config bytes
`timescale 1ns/1ps
`include "esp_map.svh"
module esp_top #(
    parameter esp_pkg::esp_byte_t NV0_INIT = 8'h00, // Plain default
    parameter esp_pkg::esp_byte_t NV1_INIT = 8'h00  // Plain default
) (
    // System clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    // Programmer pins, link side
    input wire logic link_clk_in,
    input wire logic transfer_strobe_in,
    input wire logic serial_data_in,
    // Programmer pins, system side
    input wire logic cfg_mode_in,
    input wire logic prog_pulse_in,
    // Serial read-back pin
    output logic serial_data_out,
    output logic serial_data_oe_out,
    // Status to the rest of the chip
    output logic serial_mode_out,
    output logic write_pending_out,
    output logic frame_drop_out,
    // Stored configuration bytes
    output esp_pkg::esp_byte_t nv_reg0_out,
    output esp_pkg::esp_byte_t nv_reg1_out
);
    import esp_pkg::*;

    // ---------------- Link domain ----------------
    logic [`ESP_CNT_W-1:0] bit_cnt_r; // Edges seen in this frame
    logic [`ESP_CNT_W-1:0] bit_cnt_nxt;
    logic rd_r; // Frame is a read
    logic rd_nxt;
    esp_addr_t rd_addr_r; // Address latched for read-back
    esp_addr_t rd_addr_nxt;
    logic so_r; // Serial output bit
    logic so_nxt;
    logic [`ESP_FRAME_BITS-1:0] shift_r; // Kept after the frame ends
    logic [`ESP_FRAME_BITS-1:0] shift_nxt;
    logic done_r; // Last edge was exactly the sixteenth
    logic done_nxt;
    logic [15:0] nv_link; // Stored bytes seen from link domain
    esp_byte_t rd_val; // Byte chosen for read-back

    // Stored bytes cross into the link clock; they only move on commit or system reset
    esp_sync #(.WIDTH(16)) u_nv_sync (
        .clk_in(link_clk_in),
        .rst_b_in(1'b1),
        .en_in(1'b1),
        .d_in({nv_reg1_out, nv_reg0_out}),
        .q_out(nv_link)
    );

    // Pick the addressed byte; unused addresses read as zero
    always_comb begin
        rd_val = 8'h00;
        unique case (rd_addr_r)
            2'h0: rd_val = nv_link[7:0];
            2'h1: rd_val = nv_link[15:8];
            default: rd_val = 8'h00;
        endcase
    end

    // Next values at each shift clock edge
    always_comb begin
        bit_cnt_nxt = bit_cnt_r;
        rd_nxt = rd_r;
        rd_addr_nxt = rd_addr_r;
        so_nxt = 1'b0;
        // Saturate so an over-long frame never looks complete
        if (bit_cnt_r != `ESP_CNT_MAX) begin
            bit_cnt_nxt = bit_cnt_r + 5'h01;
        end
        // Direction bit arrives; address bits already shifted in
        if (bit_cnt_r == `ESP_CNT_RW) begin
            rd_nxt = (serial_data_in == `ESP_RW_READ);
            rd_addr_nxt = shift_r[`ESP_FRAME_BITS-1 -: 2];
        end
        // Drive data bits LSB first during the data field
        if (rd_r && bit_cnt_r >= `ESP_CNT_SO_FIRST &&
            bit_cnt_r <= `ESP_CNT_SO_LAST) begin
            so_nxt = rd_val[3'(bit_cnt_r - `ESP_CNT_SO_FIRST)];
        end
        // Bits enter at the top and walk down, first bit ends at 0
        shift_nxt = {serial_data_in, shift_r[`ESP_FRAME_BITS-1:1]};
        done_nxt = (bit_cnt_r == `ESP_CNT_LAST);
    end

    // Frame control; a low strobe clears it with no clock needed
    always_ff @(posedge link_clk_in or negedge transfer_strobe_in) begin
        if (!transfer_strobe_in) begin
            bit_cnt_r <= '0;
            rd_r <= 1'b0;
            rd_addr_r <= 2'h0;
            so_r <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            rd_r <= rd_nxt;
            rd_addr_r <= rd_addr_nxt;
            so_r <= so_nxt;
        end
    end

    // Frame data survives the strobe fall so the system side can read it
    always_ff @(posedge link_clk_in) begin
        shift_r <= shift_nxt;
        done_r <= done_nxt;
    end

    // ---------------- System domain ----------------
    logic [2:0] pins_s; // Synced mode, strobe, prog pulse
    logic mode_s;
    logic strobe_s;
    logic vpp_s;
    logic [`ESP_FRAME_BITS:0] lw_s; // Synced frame word and done flag
    logic lw_done;
    logic lw_rw;
    esp_addr_t lw_addr;
    esp_byte_t lw_data;

    // Pins cross with two flops each
    esp_sync #(.WIDTH(3)) u_pin_sync (
        .clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .d_in({prog_pulse_in, transfer_strobe_in, cfg_mode_in}),
        .q_out(pins_s)
    );

    // Frame word is static once the strobe is low; settle covers it
    esp_sync #(.WIDTH(`ESP_FRAME_BITS + 1)) u_word_sync (
        .clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .en_in(clk_en_in),
        .d_in({done_r, shift_r}),
        .q_out(lw_s)
    );

    assign mode_s = pins_s[0];
    assign strobe_s = pins_s[1];
    assign vpp_s = pins_s[2];
    assign lw_done = lw_s[`ESP_FRAME_BITS];
    assign lw_rw = lw_s[`ESP_RW_BIT];
    assign lw_addr = lw_s[`ESP_ADDR_HI:`ESP_ADDR_LO];
    assign lw_data = lw_s[`ESP_DATA_HI:`ESP_DATA_LO];

    esp_state_t state_r; // Frame tracking
    esp_state_t state_nxt;
    logic [1:0] wait_r; // Settle countdown
    logic [1:0] wait_nxt;
    logic vpp_q_r; // Previous prog pulse level
    logic vpp_q_nxt;
    logic mode_r; // Serial mode flag out
    logic mode_nxt;
    logic pend_r; // Holding register holds a write
    logic pend_nxt;
    esp_addr_t hold_addr_r; // Holding register address
    esp_addr_t hold_addr_nxt;
    esp_byte_t hold_data_r; // Holding register data
    esp_byte_t hold_data_nxt;
    esp_byte_t nv_r [`ESP_NV_COUNT]; // Stored configuration bytes
    esp_byte_t nv_nxt [`ESP_NV_COUNT];
    logic drop_r; // Discard pulse
    logic drop_nxt;
    logic eval; // Frame word is settled this cycle
    logic commit; // Prog pulse rising edge acts

    assign eval = (state_r == ESP_SETTLE) && (wait_r == 2'h0);
    assign commit = vpp_s && !vpp_q_r && pend_r && mode_s;

    // Next state of frame tracking, holding register and store
    always_comb begin
        state_nxt = state_r;
        wait_nxt = wait_r;
        pend_nxt = pend_r;
        hold_addr_nxt = hold_addr_r;
        hold_data_nxt = hold_data_r;
        nv_nxt = nv_r;
        drop_nxt = 1'b0;
        vpp_q_nxt = vpp_s;
        mode_nxt = mode_s;
        // Commit moves the held word and empties the holding register
        if (commit) begin
            if (hold_addr_r == 2'h0) begin
                nv_nxt[0] = hold_data_r;
            end else if (hold_addr_r == 2'h1) begin
                nv_nxt[1] = hold_data_r;
            end
            pend_nxt = 1'b0;
        end
        unique case (state_r)
            ESP_IDLE: begin
                if (strobe_s && mode_s) begin
                    state_nxt = ESP_OPEN;
                end
            end
            ESP_OPEN: begin
                if (!strobe_s) begin
                    state_nxt = ESP_SETTLE;
                    wait_nxt = `ESP_SETTLE;
                end
            end
            ESP_SETTLE: begin
                if (wait_r != 2'h0) begin
                    wait_nxt = wait_r - 2'h1;
                end else begin
                    state_nxt = ESP_IDLE;
                    // Written last so a new write wins over a commit
                    if (!lw_done) begin
                        drop_nxt = 1'b1;
                    end else if (lw_rw != `ESP_RW_READ) begin
                        pend_nxt = 1'b1;
                        hold_addr_nxt = lw_addr;
                        hold_data_nxt = lw_data;
                    end
                end
            end
            default: state_nxt = ESP_IDLE;
        endcase
        // Leaving serial mode abandons any frame or pending write
        if (!mode_s) begin
            state_nxt = ESP_IDLE;
            pend_nxt = 1'b0;
        end
    end

    // Register system state; frozen while enable is low
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            state_r <= ESP_IDLE;
            wait_r <= 2'h0;
            vpp_q_r <= 1'b0;
            mode_r <= 1'b0;
            pend_r <= 1'b0;
            hold_addr_r <= 2'h0;
            hold_data_r <= 8'h00;
            nv_r[0] <= NV0_INIT;
            nv_r[1] <= NV1_INIT;
            drop_r <= 1'b0;
        end else if (clk_en_in) begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            vpp_q_r <= vpp_q_nxt;
            mode_r <= mode_nxt;
            pend_r <= pend_nxt;
            hold_addr_r <= hold_addr_nxt;
            hold_data_r <= hold_data_nxt;
            nv_r <= nv_nxt;
            drop_r <= drop_nxt;
        end
    end

    // Outputs
    assign serial_data_out = so_r;
    assign serial_data_oe_out = mode_r;
    assign serial_mode_out = mode_r;
    assign write_pending_out = pend_r;
    assign frame_drop_out = drop_r;
    assign nv_reg0_out = nv_r[0];
    assign nv_reg1_out = nv_r[1];

    // ---------------- Checks ----------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in || !clk_en_in);

    // Strobe fall leads to evaluation after the settle wait
    sequence frame_end_s;
        state_r == ESP_OPEN && !strobe_s && mode_s;
    endsequence
    // Open to settle takes one edge, then three countdown edges to eval
    sequence settled_s;
        ##4 (eval || !mode_r);
    endsequence

    settle_time_a: assert property (frame_end_s |-> settled_s)
        else $error("frame not evaluated after settle wait");
    mode_off_a: assert property (!mode_s |=> !pend_r && !mode_r)
        else $error("serial mode state kept with mode pin low");
    commit_r0_a: assert property (commit && hold_addr_r == 2'h0 |=>
        nv_reg0_out == $past(hold_data_r) && $stable(nv_reg1_out))
        else $error("commit to register 0 wrong");
    one_pulse_a: assert property (commit && !eval |=> !pend_r)
        else $error("holding register not emptied by commit");
    drop_short_a: assert property (eval && !lw_done && mode_s |=>
        frame_drop_out && $stable(nv_reg0_out) && $stable(nv_reg1_out))
        else $error("short frame not discarded");
    write_load_a: assert property (eval && lw_done && !lw_rw && mode_s |=>
        pend_r && hold_data_r == $past(lw_s[`ESP_DATA_HI:`ESP_DATA_LO]))
        else $error("write frame not loaded into holding register");
    read_bit0_a: assert property (@(posedge link_clk_in)
        disable iff (!transfer_strobe_in)
        rd_r && bit_cnt_r == `ESP_CNT_SO_FIRST |=> so_r == $past(rd_val[0]))
        else $error("first read-back bit wrong");
    read_quiet_a: assert property (@(posedge link_clk_in)
        disable iff (!transfer_strobe_in)
        !rd_r |-> !so_r)
        else $error("serial output driven on a write frame");
endmodule

// File: testbench/esp_prog_model.sv
// Programmer model: drives the shift clock, strobe, data, mode and prog pins
`timescale 1ns/1ps
module esp_prog_model (
    // System clock, used only to align mode and prog changes and frame starts
    input wire logic sys_clk_in,
    // Read-back pin from the port
    input wire logic serial_data_in,
    input wire logic serial_data_oe_in,
    // Pins driven towards the port
    output logic link_clk_out,
    output logic transfer_strobe_out,
    output logic serial_data_out,
    output logic cfg_mode_out,
    output logic prog_pulse_out
);
    localparam real HALF = 24.0; // Half of the 48 ns shift clock
    logic rd_bit; // Level on the read-back pin, z while not driven

    // Undriven pin reads as z so a missing enable never matches
    assign rd_bit = serial_data_oe_in ? serial_data_in : 1'bz;

    // Quiet pins at start: strobe low keeps the link frame control cleared
    initial begin
        link_clk_out = 1'b0;
        transfer_strobe_out = 1'b0;
        serial_data_out = 1'b0;
        cfg_mode_out = 1'b0;
        prog_pulse_out = 1'b0;
    end

    // Mode entry keeps prog pin at ground; mode low leaves config mode
    task automatic set_mode(input logic m);
        @(posedge sys_clk_in);
        #1;
        prog_pulse_out = 1'b0;
        cfg_mode_out = m;
    endtask

    // One frame, LSB first; clock runs only inside the frame
    task automatic frame(input logic [15:0] w, input int n,
                         output logic [7:0] rd);
        int i;
        rd = 8'h00;
        @(posedge sys_clk_in);
        #1;
        transfer_strobe_out = 1'b1;
        for (i = 0; i < n; i++) begin
            serial_data_out = w[i % 16];
            #HALF link_clk_out = 1'b1;
            #HALF link_clk_out = 0;
            // Read bits are settled by the falling edge
            if (i >= 7 && i <= 14) begin
                rd[i-7] = rd_bit;
            end
        end
        #HALF transfer_strobe_out = 1'b0;
        // Released line must not keep showing the last bit
        serial_data_out = ~serial_data_out;
    endtask

    // Prog pulse, shortened: the port does not time its length
    task automatic pulse(input int cyc);
        @(posedge sys_clk_in);
        #1;
        prog_pulse_out = 1'b1;
        repeat (cyc) @(posedge sys_clk_in);
        #1;
        prog_pulse_out = 1'b0;
    endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the serial program port
`timescale 1ns/1ps
module tb;
    import esp_pkg::*;
    // One ordinary case: write, commit, read back
    typedef struct {esp_addr_t addr; esp_byte_t data;} esp_row_t;
    logic sys_clk, rst_b, clk_en; // Clock, reset, enable
    logic lclk, strobe, sdi, mode, prog; // Programmer pins
    logic sdo, sdo_oe, mode_o, pend, drop; // Port outputs
    esp_byte_t nv0, nv1; // Stored bytes
    esp_byte_t exp_nv [4] = '{8'h00, 8'h00, 8'h00, 8'h00}; // Model
    esp_row_t rows [5] = '{'{2'h0, 8'ha5}, '{2'h1, 8'h3c},
        '{2'h0, 8'h01}, '{2'h1, 8'h80}, '{2'h2, 8'hff}};
    int err_count = 0;
    int check_count = 0;
    logic [7:0] rd; // Read-back byte
    logic hit; // Wait outcome

    esp_top dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
        .clk_en_in(clk_en), .link_clk_in(lclk),
        .transfer_strobe_in(strobe), .serial_data_in(sdi),
        .cfg_mode_in(mode), .prog_pulse_in(prog),
        .serial_data_out(sdo), .serial_data_oe_out(sdo_oe),
        .serial_mode_out(mode_o), .write_pending_out(pend),
        .frame_drop_out(drop), .nv_reg0_out(nv0), .nv_reg1_out(nv1));
    esp_prog_model prog_m (.sys_clk_in(sys_clk), .serial_data_in(sdo),
        .serial_data_oe_in(sdo_oe), .link_clk_out(lclk),
        .transfer_strobe_out(strobe), .serial_data_out(sdi),
        .cfg_mode_out(mode), .prog_pulse_out(prog));

    // 20 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Counts, verdict and end of run
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Status flag picked by number: 0 pending, 1 drop, 2 mode
    function automatic logic pick(input int s);
        return (s == 0) ? pend : (s == 1) ? drop : mode_o;
    endfunction

    // Bounded wait for a flag level
    task automatic wait_for(input int s, input logic lvl, output logic h);
        int i;
        h = 1'b0;
        for (i = 0; i < 30 && h !== 1'b1; i++) begin
            @(posedge sys_clk);
            #2;
            if (pick(s) === lvl) begin
                h = 1'b1;
            end
        end
    endtask

    // Wait that must succeed; a spent bound ends the run
    task automatic need(input int s, input logic lvl);
        logic h;
        wait_for(s, lvl, h);
        chk(8'(h), 8'h01);
        if (h !== 1'b1) begin
            complete_run();
        end
    endtask

    // Frame plus the idle gap the port needs between frames
    task automatic send(input logic [15:0] w, input int n);
        prog_m.frame(w, n, rd);
        repeat (12) @(posedge sys_clk);
    endtask

    // Read frame with a junk data field, which must be ignored
    task automatic read_check(input esp_addr_t a);
        send({8'hff, 5'h00, 1'b1, a}, 16);
        chk(rd, exp_nv[a]);
        chk(8'(pend), 8'h00);
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        prog_m.set_mode(1'b1);
        need(2, 1'b1);
        chk(8'(sdo_oe), 8'h01);
        repeat (4) @(posedge sys_clk);
        // Ordinary cases: write, commit, check, read back
        foreach (rows[k]) begin
            send({rows[k].data, 5'h00, 1'b0, rows[k].addr}, 16);
            need(0, 1'b1);
            prog_m.pulse(8);
            need(0, 1'b0);
            if (rows[k].addr < 2) begin
                exp_nv[rows[k].addr] = rows[k].data;
            end
            chk(nv0, exp_nv[0]);
            chk(nv1, exp_nv[1]);
            read_check(rows[k].addr);
            $display("test row %0d done", k);
        end
        // Frames one edge short and one edge long are dropped
        for (int n = 15; n <= 17; n += 2) begin
            prog_m.frame({8'h77, 5'h00, 1'b0, 2'h0}, n, rd);
            need(1, 1'b1);
            repeat (12) @(posedge sys_clk);
            chk(8'(pend), 8'h00);
            prog_m.pulse(8);
            repeat (6) @(posedge sys_clk);
            chk(nv0, exp_nv[0]);
        end
        $display("test bad length done");
        // Mode low drops a pending write and the pin drive
        send({8'h5a, 5'h00, 1'b0, 2'h1}, 16);
        need(0, 1'b1);
        // Enable low freezes the port, so a prog pulse goes unseen
        @(posedge sys_clk);
        #1;
        clk_en = 1'b0;
        prog_m.pulse(8);
        repeat (4) @(posedge sys_clk);
        #1;
        chk(8'(pend), 8'h01);
        chk(nv1, exp_nv[1]);
        clk_en = 1'b1;
        $display("test clock enable done");
        prog_m.set_mode(1'b0);
        need(2, 1'b0);
        chk(8'(sdo_oe), 8'h00);
        chk(8'(pend), 8'h00);
        // Frame while not in mode is ignored
        send({8'h66, 5'h00, 1'b0, 2'h0}, 16);
        wait_for(0, 1'b1, hit);
        chk(8'(hit), 8'h00);
        prog_m.pulse(8);
        repeat (6) @(posedge sys_clk);
        chk(nv0, exp_nv[0]);
        chk(nv1, exp_nv[1]);
        $display("test mode exit done");
        // Second reset in mid-run, with a write pending
        prog_m.set_mode(1'b1);
        need(2, 1'b1);
        repeat (4) @(posedge sys_clk);
        send({8'hc3, 5'h00, 1'b0, 2'h1}, 16);
        need(0, 1'b1);
        @(posedge sys_clk);
        #1;
        rst_b = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        chk(nv0, 8'h00);
        chk(nv1, 8'h00);
        chk(8'(mode_o), 8'h00);
        chk(8'(pend), 8'h00);
        rst_b = 1'b1;
        // Mode must come back through both sync stages, not at once
        repeat (2) @(posedge sys_clk);
        #1;
        chk(8'(mode_o), 8'h00);
        need(2, 1'b1);
        exp_nv = '{default: 8'h00};
        repeat (4) @(posedge sys_clk);
        // Cleared store must read back as cleared
        read_check(2'h1);
        $display("test reset done");
        complete_run();
    end
endmodule
